// ==== hw/sss_pkg.sv ====
/*
 * shared constants and types for the speed command source selector.
 * assumes nothing beyond a tool that reads SystemVerilog packages.
 */
package sss_pkg;

    // ---------------------------------------------------------------
    // selection setting and preset table
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SSS_SEL_ANALOG,  // analog command only
        SSS_SEL_PRESET4, // four presets from two inputs
        SSS_SEL_MIXED,   // three presets, analog on code 11
        SSS_SEL_PRESET8  // eight presets from three inputs
    } sss_sel_t;

    localparam int SSS_SPEED_W = 16;
    localparam int SSS_IDX_W = 3;
    localparam int SSS_PRESET_COUNT = 8;
    localparam sss_sel_t SSS_SEL_RESET = SSS_SEL_ANALOG;
    localparam logic [SSS_IDX_W-1:0] SSS_IDX_RESET = 3'h0;
    localparam logic [1:0] SSS_CODE_BOTH = 2'h3;

    // ---------------------------------------------------------------
    // index decode
    // ---------------------------------------------------------------
    // preset address for a setting and the three contact bits
    function automatic logic [SSS_IDX_W-1:0] sss_addr(input sss_sel_t sel, input logic [SSS_IDX_W-1:0] idx);
        sss_addr = (sel == SSS_SEL_PRESET8) ? idx : {1'b0, idx[1:0]};
    endfunction

    // true where the analog command wins
    function automatic logic sss_use_analog(input sss_sel_t sel, input logic [SSS_IDX_W-1:0] idx);
        sss_use_analog = (sel == SSS_SEL_ANALOG) || ((sel == SSS_SEL_MIXED) && (idx[1:0] == SSS_CODE_BOTH));
    endfunction

endpackage

// ==== hw/sss_mem_if.sv ====
/*
 * interface between the selector and its preset store.
 * assumes both ends share ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

interface sss_mem_if #(
    parameter int W = 16
);
    logic wr_en;
    logic [2:0] wr_addr;
    logic [W-1:0] wr_data;
    logic [2:0] rd_addr;
    logic [W-1:0] rd_data;

    modport host (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

`default_nettype wire

// ==== hw/sss_preset_mem.sv ====
/*
 * eight-word store of preset speeds with registered read data.
 * assumes writes and reads come from logic on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module sss_preset_mem #(
    parameter int W = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // access port
    sss_mem_if.mem bus
);
    import sss_pkg::*;

    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [W-1:0] rd_q;
    logic [W-1:0] rd_d;

    // ---------------------------------------------------------------
    // next values: one word written, one word read
    // ---------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (bus.wr_en) begin
            mem_d[bus.wr_addr] = bus.wr_data;
        end
        rd_d = mem_q[bus.rd_addr];
    end

    // registers, cleared to zero speed
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            rd_q <= '0;
        end else begin
            mem_q <= mem_d;
            rd_q <= rd_d;
        end
    end

    assign bus.rd_data = rd_q;

endmodule // sss_preset_mem

`default_nettype wire

// ==== hw/sss_speed_select.sv ====
/*
 * speed command source selector for velocity control: picks the
 * analog command or one of eight presets from a setting and three
 * contact inputs, with optional zero clamp.
 * assumes contact and clamp pins are asynchronous; the analog word,
 * mode, setting and preset writes come from logic on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RQ1 - selection applies only in velocity control
// RQ2 - setting 0..3, factory default is 0
// RQ3 - setting 0 always uses analog command
// RQ4 - setting 1: inputs one/two pick four presets
// RQ5 - settings 1,2 ignore third input
// RQ6 - setting 2: three presets, analog on 11
// RQ7 - setting 3: three inputs index eight presets
// RQ8 - setting 3, third closed: presets five-eight
// RQ9 - controller uses servo-on and clamp to stop
// RQ10 - enabled clamp open forces zero speed
// RQ11 - sync contacts, register output, reset zero
// RQ12 - closed contact is one, open zero
module sss_speed_select #(
    parameter int W = sss_pkg::SSS_SPEED_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // mode and setting
    input wire logic velocity_mode,
    input wire sss_pkg::sss_sel_t speed_source_select,
    input wire logic select_load,
    input wire logic factory_default,
    input wire logic zero_clamp_enable,
    // contact pins, high while closed
    input wire logic preset_index_bit0,
    input wire logic preset_index_bit1,
    input wire logic preset_index_bit2,
    input wire logic speed_zero_clamp_in,
    // commands
    input wire logic [W-1:0] analog_speed_command,
    input wire logic preset_wr_en,
    input wire logic [2:0] preset_wr_addr,
    input wire logic [W-1:0] preset_wr_data,
    // result
    output logic [W-1:0] speed_cmd_q,
    output logic source_analog_q,
    output logic [2:0] preset_addr_q,
    output sss_pkg::sss_sel_t select_q
);
    import sss_pkg::*;

    sss_mem_if #(.W(W)) mem_bus ();

    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    logic [3:0] pins;
    logic [2:0] idx_s;
    logic clamp_s;
    sss_sel_t select_d;
    logic use_analog_d;
    logic [2:0] addr_d;
    logic zero_d;
    logic zero_q;
    logic [W-1:0] ana_d;
    logic [W-1:0] ana_q;
    logic [W-1:0] speed_d;

    // ---------------------------------------------------------------
    // pin synchroniser
    // ---------------------------------------------------------------
    assign pins = {speed_zero_clamp_in, preset_index_bit2, preset_index_bit1, preset_index_bit0};

    // two flops per pin before any use
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
        end else begin
            pin_meta_q <= pins; // [RQ11]
            pin_sync_q <= pin_meta_q;
        end
    end

    assign idx_s = pin_sync_q[2:0]; // closed reads as one [RQ12]
    assign clamp_s = pin_sync_q[3];

    // ---------------------------------------------------------------
    // selection setting
    // ---------------------------------------------------------------
    // factory default beats a load in the same cycle
    always_comb begin
        select_d = select_q;
        if (factory_default) begin
            select_d = SSS_SEL_RESET; // [RQ2]
        end else if (select_load) begin
            select_d = speed_source_select;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            select_q <= SSS_SEL_RESET; // [RQ2]
        end else begin
            select_q <= select_d;
        end
    end

    // ---------------------------------------------------------------
    // source decode, aligned with preset read
    // ---------------------------------------------------------------
    always_comb begin
        use_analog_d = sss_use_analog(select_q, idx_s); // [RQ3] [RQ6]
        addr_d = sss_addr(select_q, idx_s); // [RQ4] [RQ5] [RQ7] [RQ8]
        zero_d = !velocity_mode || (zero_clamp_enable && !clamp_s); // [RQ1] [RQ10]
        ana_d = analog_speed_command;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            source_analog_q <= 1'b0;
            preset_addr_q <= SSS_IDX_RESET;
            zero_q <= 1'b1;
            ana_q <= '0;
        end else begin
            source_analog_q <= use_analog_d;
            preset_addr_q <= addr_d;
            zero_q <= zero_d;
            ana_q <= ana_d;
        end
    end

    // preset store, read data one cycle after address
    assign mem_bus.wr_en = preset_wr_en;
    assign mem_bus.wr_addr = preset_wr_addr;
    assign mem_bus.wr_data = preset_wr_data;
    assign mem_bus.rd_addr = addr_d;

    sss_preset_mem #(.W(W), .DEPTH(SSS_PRESET_COUNT)) i_sss_preset_mem (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .bus(mem_bus)
    );

    // ---------------------------------------------------------------
    // output command
    // ---------------------------------------------------------------
    // clamp or non-velocity mode overrides the source
    always_comb begin
        if (zero_q) begin
            speed_d = '0; // [RQ10]
        end else if (source_analog_q) begin
            speed_d = ana_q;
        end else begin
            speed_d = mem_bus.rd_data;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            speed_cmd_q <= '0; // [RQ11]
        end else begin
            speed_cmd_q <= speed_d;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_pins_steady;
        ($stable(pins)) [*2];
    endsequence

    sequence s_clamp_hold;
        velocity_mode && zero_clamp_enable && !clamp_s;
    endsequence

    chk_sync_two_flops: assert property (s_pins_steady |=> pin_sync_q == $past(pins)) // [RQ11]
        else $error("synchronised pins differ from steady pins");
    chk_not_velocity_zero: assert property (!velocity_mode |-> ##2 speed_cmd_q == '0) // [RQ1]
        else $error("speed not zero outside velocity control");
    chk_sel0_analog: assert property ((select_q == SSS_SEL_ANALOG) |=> source_analog_q) // [RQ3]
        else $error("setting 0 did not pick analog");
    chk_analog_passes: assert property ((velocity_mode && !zero_d && use_analog_d) |-> ##2
        speed_cmd_q == $past(analog_speed_command, 2)) // [RQ3]
        else $error("analog command not passed through");
    chk_sel1_four: assert property ((select_q == SSS_SEL_PRESET4) |=>
        (!source_analog_q && preset_addr_q == {1'b0, $past(idx_s[1:0])})) // [RQ4]
        else $error("setting 1 preset address wrong");
    chk_third_ignored: assert property ((select_q == SSS_SEL_PRESET4 || select_q == SSS_SEL_MIXED) |=>
        !preset_addr_q[2]) // [RQ5]
        else $error("third input used in setting 1 or 2");
    chk_sel2_mixed: assert property ((select_q == SSS_SEL_MIXED) |=>
        source_analog_q == ($past(idx_s[1:0]) == 2'h3)) // [RQ6]
        else $error("setting 2 analog choice wrong");
    chk_sel3_eight: assert property ((select_q == SSS_SEL_PRESET8) |=>
        (!source_analog_q && preset_addr_q == $past(idx_s))) // [RQ7]
        else $error("setting 3 preset address wrong");
    chk_sel3_upper: assert property ((select_q == SSS_SEL_PRESET8 && pin_sync_q[2]) |=> preset_addr_q[2]) // [RQ8]
        else $error("setting 3 upper bank not chosen");
    chk_clamp_zero: assert property (s_clamp_hold |-> ##2 speed_cmd_q == '0) // [RQ10]
        else $error("open clamp did not force zero");
    chk_default_sel: assert property (factory_default |=> select_q == SSS_SEL_RESET) // [RQ2]
        else $error("factory default did not restore setting 0");
    // index mapping, load path, lower bank and reset value
    chk_closed_is_one: assert property (s_pins_steady |=> // [RQ12]
        idx_s == $past({preset_index_bit2, preset_index_bit1, preset_index_bit0}))
        else $error("contact index bits out of order");
    chk_load_sel: assert property ((select_load && !factory_default) |=> // [RQ2]
        select_q == $past(speed_source_select))
        else $error("loaded setting not taken");
    chk_sel3_lower: assert property ((select_q == SSS_SEL_PRESET8 && !pin_sync_q[2]) |=> !preset_addr_q[2]) // [RQ8]
        else $error("setting 3 lower bank not chosen");
    chk_reset_zero: assert property (disable iff (1'b0) !resetn |=> // [RQ11]
        (speed_cmd_q == '0 && select_q == SSS_SEL_RESET))
        else $error("reset did not clear command and setting");

endmodule // sss_speed_select

`default_nettype wire

// ==== sim/sss_ctrl_model.sv ====
/* external controller model: drives the contact and clamp pins.
   assumes the bench sets code and run just after falling edges. */
`timescale 1ns/1ps
`default_nettype none
module sss_ctrl_model (
    // clock
    input wire logic ref_clk,
    // request from bench
    input wire logic [2:0] code,
    input wire logic run,
    // contact pins, high while closed
    output var logic preset_index_bit0,
    output var logic preset_index_bit1,
    output var logic preset_index_bit2,
    output var logic speed_zero_clamp_in
);
    // pins open at time zero, then follow the request after each falling edge
    initial begin
        {preset_index_bit2, preset_index_bit1, preset_index_bit0, speed_zero_clamp_in} = 4'h0;
        forever begin
            @(negedge ref_clk);
            #1;
            {preset_index_bit2, preset_index_bit1, preset_index_bit0} = code; // closed is one
            speed_zero_clamp_in = run; // open clamp stops the motor while zero_clamp_enable is set
        end
    end
endmodule // sss_ctrl_model
`default_nettype wire

// ==== sim/sss_speed_select_bench.sv ====
/* self-checking bench for the speed command source selector.
   assumes the package, interface, design and controller model. */
`timescale 1ns/1ps
`default_nettype none
module sss_speed_select_bench;
    import sss_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic velocity_mode = 1'b1;
    sss_sel_t speed_source_select = SSS_SEL_ANALOG;
    sss_sel_t cur = SSS_SEL_ANALOG;
    sss_sel_t select_q;
    logic select_load = 1'b0;
    logic factory_default = 1'b0;
    logic zero_clamp_enable = 1'b0;
    logic [2:0] code = 3'h0;
    logic run = 1'b1;
    logic b0, b1, b2, clamp;
    logic [15:0] analog = 16'h1234;
    logic wr_en = 1'b0;
    logic [2:0] wr_addr = 3'h0;
    logic [15:0] wr_data = 16'h0000;
    logic [15:0] speed_cmd_q;
    logic src_an;
    logic [15:0] pr [8];
    logic [18:0] notes [$];
    logic [18:0] exp_v;
    int err_count = 0;
    int n_compared = 0;
    int seed = 32'h89dceac6;

    // clock, 100 ns period
    always #50 ref_clk = ~ref_clk;

    sss_speed_select #(.W(SSS_SPEED_W)) i_sss_speed_select (
        .ref_clk(ref_clk), .resetn(resetn), .velocity_mode(velocity_mode),
        .speed_source_select(speed_source_select), .select_load(select_load),
        .factory_default(factory_default), .zero_clamp_enable(zero_clamp_enable),
        .preset_index_bit0(b0), .preset_index_bit1(b1), .preset_index_bit2(b2),
        .speed_zero_clamp_in(clamp), .analog_speed_command(analog), .preset_wr_en(wr_en),
        .preset_wr_addr(wr_addr), .preset_wr_data(wr_data), .speed_cmd_q(speed_cmd_q),
        .source_analog_q(src_an), .preset_addr_q(), .select_q(select_q)
    );
    sss_ctrl_model i_sss_ctrl_model (
        .ref_clk(ref_clk), .code(code), .run(run), .preset_index_bit0(b0),
        .preset_index_bit1(b1), .preset_index_bit2(b2), .speed_zero_clamp_in(clamp)
    );

    // ---------------------------------------------------------------
    // expectation and comparison
    // ---------------------------------------------------------------
    // expected command from setting, contact code and analog word
    function automatic logic [15:0] expv(input sss_sel_t s, input logic [2:0] c, input logic [15:0] a);
        case (s)
            SSS_SEL_ANALOG: expv = a;
            SSS_SEL_PRESET4: expv = pr[{1'b0, c[1:0]}];
            SSS_SEL_MIXED: expv = (c[1:0] == 2'h3) ? a : pr[{1'b0, c[1:0]}];
            default: expv = pr[c];
        endcase
    endfunction

    // analog source flag from setting and contact code
    function automatic logic expf(input sss_sel_t s, input logic [2:0] c);
        expf = (s == SSS_SEL_ANALOG) || ((s == SSS_SEL_MIXED) && (c[1:0] == 2'h3));
    endfunction

    // let the path settle, then leave a note for the monitor; flag is clear in reset
    task automatic note(input logic [15:0] s);
        repeat (6) @(negedge ref_clk);
        notes.push_back({cur, (resetn ? expf(cur, code) : 1'b0), s});
        @(negedge ref_clk);
    endtask

    // one load pulse, optionally with factory default
    task automatic setsel(input sss_sel_t s, input logic fd);
        speed_source_select = s;
        select_load = 1'b1;
        factory_default = fd;
        @(negedge ref_clk);
        select_load = 1'b0;
        factory_default = 1'b0;
        cur = fd ? SSS_SEL_ANALOG : s;
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // take the oldest note after each rising edge
    always @(posedge ref_clk) begin
        #5;
        if (notes.size() > 0) begin
            exp_v = notes.pop_front();
            n_compared++;
            if ({select_q, src_an, speed_cmd_q} !== exp_v) begin
                err_count++;
                $display("mismatch at %0t: got %h expected %h", $time, {select_q, src_an, speed_cmd_q}, exp_v);
            end
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        note(16'h0000);
        repeat (13) @(negedge ref_clk);
        resetn = 1'b1;
        for (int i = 0; i < 8; i++) begin
            pr[i] = 16'($random(seed));
            wr_en = 1'b1;
            wr_addr = i[2:0];
            wr_data = pr[i];
            @(negedge ref_clk);
        end
        wr_en = 1'b0;
        // every setting against every contact code
        for (int s = 0; s < 4; s++) begin
            setsel(sss_sel_t'(s[1:0]), 1'b0);
            for (int c = 0; c < 8; c++) begin
                code = c[2:0];
                analog = 16'($random(seed));
                note(expv(cur, code, analog));
            end
        end
        zero_clamp_enable = 1'b1;
        run = 1'b0;
        note(16'h0000);
        run = 1'b1;
        note(expv(cur, code, analog));
        zero_clamp_enable = 1'b0;
        run = 1'b0;
        note(expv(cur, code, analog));
        velocity_mode = 1'b0;
        note(16'h0000);
        velocity_mode = 1'b1;
        setsel(SSS_SEL_PRESET8, 1'b1);
        note(analog);
        setsel(SSS_SEL_PRESET8, 1'b0);
        resetn = 1'b0;
        cur = SSS_SEL_ANALOG;
        note(16'h0000);
        resetn = 1'b1;
        note(analog);
        setsel(SSS_SEL_PRESET8, 1'b0);
        note(16'h0000);
        tally_and_finish();
    end

    // watchdog, far beyond the expected run
    initial begin
        #1000000;
        err_count++;
        tally_and_finish();
    end
endmodule // sss_speed_select_bench
`default_nettype wire
